// ---- hdl/lxs_pkg.sv ----
// Purpose: shared constants for the lin control / transceiver status register bank
// Assumes: 200 MHz system clock, byte-wide register port
// Notes: time-outs are given in microseconds and turned into cycle counts here
package lxs_pkg;
  // register addresses
  localparam logic [6:0] ADDR_LIN_CTRL = 7'h21; // lin_channel_control
  localparam logic [6:0] ADDR_XCVR_STAT = 7'h22; // transceiver_state
  // reset value of lin_channel_control (both channels offline)
  localparam logic [7:0] LIN_CTRL_RST = 8'h00;
  // bits of the second channel, kept clear on single-channel builds
  localparam logic [7:0] LIN_B_MASK = 8'hf0;
  // field layout inside one channel nibble
  localparam int FLD_OP_LSB = 0; // lin_op_sel
  localparam int FLD_SLOPE_LSB = 2; // slope select
  localparam int CH_STRIDE = 4; // nibble per channel
  // status bit positions
  localparam int ST_CTS = 7; // transmitter ready
  localparam int ST_PNERR = 6; // selective_wake_fault
  localparam int ST_PNS = 5; // selective_wake_cfg_state
  localparam int ST_OSC = 4; // selective_wake_osc_locked
  localparam int ST_QUIET = 3; // can_bus_quiet
  // slope codes
  localparam logic [1:0] SLOPE_NO_DTO = 2'h2; // slope on, time-out off
  localparam logic [1:0] SLOPE_RSVD = 2'h3; // reserved
  // op codes
  localparam logic [1:0] OP_OFF = 2'h0;
  localparam logic [1:0] OP_LISTEN = 2'h3;
  // timing
  localparam int CLK_MHZ = 200; // cycles per microsecond
  localparam int T_DOM_US = 10000; // dominant time-out, us
  localparam int T_SIL_US = 1000000; // bus silence time-out, us
  localparam int DOM_CYC_DEF = T_DOM_US * CLK_MHZ;
  localparam int SIL_CYC_DEF = T_SIL_US * CLK_MHZ;
  // chip operating mode as seen by the transceivers
  typedef enum logic [1:0] {
    SBC_OTHER = 2'b00,
    SBC_NORMAL = 2'b01,
    SBC_STANDBY = 2'b10
  } lxs_sbc_t;
  // lin transceiver mode
  typedef enum logic [1:0] {
    LM_OFFLINE = 2'b00,
    LM_ACTIVE = 2'b01,
    LM_LISTEN = 2'b10
  } lxs_lmode_t;
endpackage : lxs_pkg

// ---- hdl/lxs_regs.sv ----
// Purpose: lin channel control register and transceiver status register
// Assumes: register port and mode inputs are on CLK_SYS; pins are asynchronous
// Notes: status bits 2:0 belong to other logic and read as zero here
module lxs_regs import lxs_pkg::*; #(
  parameter int NUM_LIN = 2, // 1 or 2 lin channels
  parameter bit HAS_PN = 1'b1, // selective wake fitted
  parameter int DOM_CYC = DOM_CYC_DEF, // dominant time-out, cycles
  parameter int SIL_CYC = SIL_CYC_DEF // bus silence time-out, cycles
) (
  input wire logic CLK_SYS, // system clock
  input wire logic RST, // async reset, active high
  input wire logic CE, // clock enable, freezes all state when low
  input wire logic [6:0] REG_ADDR, // register address
  input wire logic [7:0] REG_WDATA, // write data
  input wire logic REG_WR, // write strobe, one cycle
  input wire logic REG_RD, // read strobe, one cycle
  output logic [7:0] REG_RDATA, // read data
  output logic REG_RVALID, // read data valid, one cycle
  input wire logic [1:0] SBC_MODE, // chip mode, lxs_sbc_t
  input wire logic LIN_VBAT_OK, // battery above lin undervoltage level
  input wire logic [NUM_LIN-1:0] LIN_TX_INPUT_N, // transmit pins, async
  input wire logic CAN_TX_READY, // can transmitter ready
  input wire logic FD_FRAME_ERROR_FLAG, // fd frame error flag
  input wire logic SELECTIVE_WAKE_CFG_VALID, // config-valid control bit
  input wire logic SELECTIVE_WAKE_OSC_LOCKED, // oscillator lock, async
  input wire logic CAN_BUS_ACTIVE, // can bus activity, async
  output logic [2*NUM_LIN-1:0] LIN_MODE, // per channel lxs_lmode_t
  output logic [NUM_LIN-1:0] LIN_TX_EN, // transmitter enabled
  output logic [NUM_LIN-1:0] LIN_RX_EN, // receiver enabled
  output logic [NUM_LIN-1:0] LIN_DOM_DRIVE, // drive bus dominant
  output logic [NUM_LIN-1:0] LIN_SLOPE_ON, // slope control active
  output logic [NUM_LIN-1:0] LIN_DTO_TRIP, // dominant time-out tripped
  output logic STD_WAKE_ONLY // wake falls back to standard pattern
);

  // register bank state
  logic [7:0] ctrl_ff; // lin_channel_control
  logic [7:0] rdata_ff; // read data
  logic rvalid_ff; // read valid
  logic std_wake_ff; // fallback flag
  // pin synchronisers
  logic osc_s1_ff;
  logic osc_s2_ff;
  logic act_s1_ff;
  logic act_s2_ff;
  // silence timer
  logic [31:0] sil_cnt_ff;
  logic quiet_ff; // can_bus_quiet

  // address decode
  wire sel_ctrl = (REG_ADDR == ADDR_LIN_CTRL);
  wire sel_stat = (REG_ADDR == ADDR_XCVR_STAT);
  wire ctrl_we = CE & REG_WR & sel_ctrl; // status writes fall on the floor
  // single-channel builds hold the second nibble at zero
  wire [7:0] ctrl_mask = (NUM_LIN > 1) ? 8'hff : ~LIN_B_MASK;
  wire [7:0] nxt_ctrl = ctrl_we ? (REG_WDATA & ctrl_mask) : ctrl_ff;

  // status word
  wire pn_fault = HAS_PN & (FD_FRAME_ERROR_FLAG | ~SELECTIVE_WAKE_CFG_VALID);
  wire pn_state = HAS_PN & SELECTIVE_WAKE_CFG_VALID;
  wire pn_osc = HAS_PN & osc_s2_ff;
  logic [7:0] stat_word;
  always_comb begin
    stat_word = 8'h00;
    stat_word[ST_CTS] = CAN_TX_READY;
    stat_word[ST_PNERR] = pn_fault;
    stat_word[ST_PNS] = pn_state;
    stat_word[ST_OSC] = pn_osc;
    stat_word[ST_QUIET] = quiet_ff;
  end

  // read mux; unmapped addresses answer zero
  wire [7:0] nxt_rdata = sel_ctrl ? ctrl_ff : (sel_stat ? stat_word : 8'h00);
  wire nxt_rvalid = REG_RD;

  // silence counter: any activity restarts it, quiet once the full time passed
  wire sil_hit = (sil_cnt_ff == 32'(SIL_CYC - 1));
  wire [31:0] nxt_sil_cnt = act_s2_ff ? 32'h0 : (quiet_ff ? sil_cnt_ff : sil_cnt_ff + 32'h1);
  wire nxt_quiet = ~act_s2_ff & (quiet_ff | sil_hit);

  // register and read path
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      ctrl_ff <= LIN_CTRL_RST;
      rdata_ff <= 8'h00;
      rvalid_ff <= 1'b0;
      std_wake_ff <= 1'b0;
    end else if (CE) begin
      ctrl_ff <= nxt_ctrl;
      rdata_ff <= nxt_rdata;
      rvalid_ff <= nxt_rvalid;
      std_wake_ff <= pn_fault;
    end
  end

  // pin synchronisers; first stage feeds only the second
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      osc_s1_ff <= 1'b0;
      osc_s2_ff <= 1'b0;
      act_s1_ff <= 1'b0;
      act_s2_ff <= 1'b0;
    end else if (CE) begin
      osc_s1_ff <= SELECTIVE_WAKE_OSC_LOCKED;
      osc_s2_ff <= osc_s1_ff;
      act_s1_ff <= CAN_BUS_ACTIVE;
      act_s2_ff <= act_s1_ff;
    end
  end

  // silence timer; reset counts as a quiet start, not as silence
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      sil_cnt_ff <= 32'h0;
      quiet_ff <= 1'b0;
    end else if (CE) begin
      sil_cnt_ff <= nxt_sil_cnt;
      quiet_ff <= nxt_quiet;
    end
  end

  assign REG_RDATA = rdata_ff;
  assign REG_RVALID = rvalid_ff;
  assign STD_WAKE_ONLY = std_wake_ff;

  // per-channel transceiver control
  genvar ch;
  generate
    for (ch = 0; ch < NUM_LIN; ch++) begin : g_lin
      logic txd_s1_ff; // first sync stage
      logic txd_s2_ff; // synced transmit pin
      logic [31:0] dom_cnt_ff; // low-time counter
      logic trip_ff; // dominant time-out latched
      logic [1:0] mode_ff;
      logic tx_en_ff;
      logic rx_en_ff;
      logic dom_ff;
      logic slope_ff;

      wire [1:0] op = ctrl_ff[ch*CH_STRIDE+FLD_OP_LSB +: 2];
      wire [1:0] slope = ctrl_ff[ch*CH_STRIDE+FLD_SLOPE_LSB +: 2];
      wire normal = (SBC_MODE == SBC_NORMAL) & LIN_VBAT_OK;
      wire standby = (SBC_MODE == SBC_STANDBY) & LIN_VBAT_OK;
      // 01 and 10 are both active; only normal mode allows it
      wire [1:0] nm_mode = (op == OP_OFF) ? LM_OFFLINE : ((op == OP_LISTEN) ? LM_LISTEN : LM_ACTIVE);
      // standby keeps only listen-only alive
      wire [1:0] sb_mode = (op == OP_LISTEN) ? LM_LISTEN : LM_OFFLINE;
      wire [1:0] nxt_mode = normal ? nm_mode : (standby ? sb_mode : LM_OFFLINE);
      // time-out is on unless slope code 10 turns it off
      wire dto_en = (slope != SLOPE_NO_DTO);
      // counter runs while the pin is low and clears on the rising edge
      wire txd_low = ~txd_s2_ff;
      // compare with >= so a time-out re-enabled on a pin that is already low trips at once
      wire dom_hit = (dom_cnt_ff >= 32'(DOM_CYC - 1));
      // counter parks at the limit, so a long low with the time-out off cannot wrap it
      wire [31:0] nxt_dom_cnt = txd_low ? ((trip_ff | dom_hit) ? dom_cnt_ff : dom_cnt_ff + 32'h1) : 32'h0;
      wire nxt_trip = txd_low & dto_en & (trip_ff | dom_hit);
      // listen-only: receiver on, transmitter off
      wire nxt_tx_en = (nxt_mode == LM_ACTIVE) & ~nxt_trip;
      wire nxt_rx_en = (nxt_mode != LM_OFFLINE);
      wire nxt_dom = nxt_tx_en & txd_low;
      wire nxt_slope = (slope != SLOPE_RSVD);

      // transmit pin synchroniser, idles high like the pin pull-up
      always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
          txd_s1_ff <= 1'b1;
          txd_s2_ff <= 1'b1;
        end else if (CE) begin
          txd_s1_ff <= LIN_TX_INPUT_N[ch];
          txd_s2_ff <= txd_s1_ff;
        end
      end

      // dominant timer and trip flag
      always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
          dom_cnt_ff <= 32'h0;
          trip_ff <= 1'b0;
        end else if (CE) begin
          dom_cnt_ff <= nxt_dom_cnt;
          trip_ff <= nxt_trip;
        end
      end

      // registered transceiver controls
      always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
          mode_ff <= LM_OFFLINE;
          tx_en_ff <= 1'b0;
          rx_en_ff <= 1'b0;
          dom_ff <= 1'b0;
          slope_ff <= 1'b1;
        end else if (CE) begin
          mode_ff <= nxt_mode;
          tx_en_ff <= nxt_tx_en;
          rx_en_ff <= nxt_rx_en;
          dom_ff <= nxt_dom;
          slope_ff <= nxt_slope;
        end
      end

      assign LIN_MODE[2*ch +: 2] = mode_ff;
      assign LIN_TX_EN[ch] = tx_en_ff;
      assign LIN_RX_EN[ch] = rx_en_ff;
      assign LIN_DOM_DRIVE[ch] = dom_ff;
      assign LIN_SLOPE_ON[ch] = slope_ff;
      assign LIN_DTO_TRIP[ch] = trip_ff;

      // checks per channel
      a_listen_no_tx: assert property (@(posedge CLK_SYS) disable iff (RST)
        mode_ff == LM_LISTEN |-> !tx_en_ff && rx_en_ff)
        else $error("listen-only channel has transmitter on");
      a_standby_off: assert property (@(posedge CLK_SYS) disable iff (RST)
        CE && SBC_MODE == SBC_STANDBY && op != OP_LISTEN |=> mode_ff == LM_OFFLINE)
        else $error("standby channel not offline");
      a_normal_active: assert property (@(posedge CLK_SYS) disable iff (RST)
        CE && normal && (op == 2'h1 || op == 2'h2) |=> mode_ff == LM_ACTIVE)
        else $error("active code did not select active");
      a_dto_trip: assert property (@(posedge CLK_SYS) disable iff (RST)
        CE && txd_low && dto_en && dom_hit |=> trip_ff && !tx_en_ff)
        else $error("dominant time-out did not disable transmitter");
      a_dto_off: assert property (@(posedge CLK_SYS) disable iff (RST)
        CE && slope == SLOPE_NO_DTO |=> !trip_ff)
        else $error("time-out tripped while deactivated");
      a_slope_on: assert property (@(posedge CLK_SYS) disable iff (RST)
        CE |=> LIN_SLOPE_ON[ch] == ($past(slope) != SLOPE_RSVD))
        else $error("slope control output wrong");
      a_dto_release: assert property (@(posedge CLK_SYS) disable iff (RST)
        CE && trip_ff && !txd_low |=> !trip_ff && dom_cnt_ff == 32'h0)
        else $error("rising edge did not restart time-out");
    end
  endgenerate

  // bank-level checks
  sequence s_ctrl_wr;
    CE && REG_WR && sel_ctrl;
  endsequence
  sequence s_rd_req;
    CE && REG_RD;
  endsequence

  a_ctrl_write: assert property (@(posedge CLK_SYS) disable iff (RST)
    s_ctrl_wr |=> ctrl_ff == ($past(REG_WDATA) & ctrl_mask))
    else $error("control write not stored");
  a_ctrl_hold: assert property (@(posedge CLK_SYS) disable iff (RST)
    CE && !(REG_WR && sel_ctrl) |=> $stable(ctrl_ff))
    else $error("control register changed without a write");
  a_read_once: assert property (@(posedge CLK_SYS) disable iff (RST)
    s_rd_req |=> REG_RVALID && REG_RDATA == $past(nxt_rdata))
    else $error("read answer missing or wrong");
  a_single_clr: assert property (@(posedge CLK_SYS) disable iff (RST)
    NUM_LIN == 1 |-> (ctrl_ff & LIN_B_MASK) == 8'h00)
    else $error("second channel bits set on single build");
  a_cts_bit: assert property (@(posedge CLK_SYS) disable iff (RST)
    stat_word[ST_CTS] == CAN_TX_READY)
    else $error("transmitter ready bit wrong");
  a_pn_bits: assert property (@(posedge CLK_SYS) disable iff (RST)
    HAS_PN |-> stat_word[ST_PNERR] == (FD_FRAME_ERROR_FLAG || !SELECTIVE_WAKE_CFG_VALID)
      && stat_word[ST_PNS] == SELECTIVE_WAKE_CFG_VALID)
    else $error("selective wake status wrong");
  a_pn_rsvd: assert property (@(posedge CLK_SYS) disable iff (RST)
    !HAS_PN |-> stat_word[6:4] == 3'h0 && stat_word[2:0] == 3'h0)
    else $error("reserved status bits not zero");
  a_osc_sync: assert property (@(posedge CLK_SYS) disable iff (RST)
    HAS_PN && CE ##1 CE |=> stat_word[ST_OSC] == $past(SELECTIVE_WAKE_OSC_LOCKED, 2))
    else $error("oscillator bit wrong");
  a_quiet_set: assert property (@(posedge CLK_SYS) disable iff (RST)
    CE && !act_s2_ff && sil_hit |=> quiet_ff)
    else $error("bus quiet not set after silence");
  a_quiet_clr: assert property (@(posedge CLK_SYS) disable iff (RST)
    CE && act_s2_ff |=> !quiet_ff && sil_cnt_ff == 32'h0)
    else $error("bus activity did not clear quiet");

  // a read of the control register returns the value held before that edge
  a_read_ctrl: assert property (@(posedge CLK_SYS) disable iff (RST)
    s_rd_req ##0 sel_ctrl |=> REG_RDATA == $past(ctrl_ff))
    else $error("control read returned wrong value");

  // valid stands one cycle after each cycle of read strobe, never without a read strobe
  a_rvalid_pulse: assert property (@(posedge CLK_SYS) disable iff (RST)
    CE && !REG_RD |=> !REG_RVALID)
    else $error("read valid without a read strobe");

  // fallback flag follows the fault condition one cycle later
  a_std_wake: assert property (@(posedge CLK_SYS) disable iff (RST)
    CE |=> STD_WAKE_ONLY == $past(HAS_PN && (FD_FRAME_ERROR_FLAG || !SELECTIVE_WAKE_CFG_VALID)))
    else $error("standard wake fallback flag wrong");

  // clock enable low must freeze the bank
  a_ce_freeze: assert property (@(posedge CLK_SYS) disable iff (RST)
    !CE |=> $stable(ctrl_ff) && $stable(REG_RVALID) && $stable(quiet_ff))
    else $error("state changed while clock enable low");

endmodule : lxs_regs

// ---- tb/lxs_host.sv ----
// Purpose: host model that reads and writes the lin control and status registers
// Assumes: strobes change at the falling edge and are taken at the next rising edge
// Notes: idle address and data lines show the inverse of their last value
module lxs_host import lxs_pkg::*; #(
  parameter int NUM_LIN = 2 // lin channels fitted
) (
  input wire logic clk, // system clock
  input wire logic [7:0] rdata, // read data
  input wire logic rvalid, // read data valid
  output logic [6:0] addr, // register address
  output logic [7:0] wdata, // write data
  output logic wr, // write strobe
  output logic rd // read strobe
);
  timeunit 1ns;
  timeprecision 100ps;
  // idle bus at time zero
  initial begin
    addr = 7'h00;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
  end

  // one write, strobe high across exactly one rising edge
  task automatic wr_reg(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] v;
    v = d;
    if (NUM_LIN == 1) begin
      v[7:4] = 4'h0; // second channel absent
    end
    if (v[3:2] == SLOPE_RSVD) begin
      v[3:2] = SLOPE_NO_DTO; // reserved slope code is never sent
    end
    if (v[7:6] == SLOPE_RSVD) begin
      v[7:6] = SLOPE_NO_DTO; // same for the second channel
    end
    @(negedge clk);
    addr = a;
    wdata = v;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
    addr = ~a;
    wdata = ~v;
  endtask : wr_reg

  // one read; data is taken while the valid flag stands, else unknown
  task automatic rd_reg(input logic [6:0] a, output logic [7:0] d);
    @(negedge clk);
    addr = a;
    rd = 1'b1;
    @(negedge clk);
    d = (rvalid === 1'b1) ? rdata : 8'hxx;
    rd = 1'b0;
    addr = ~a;
  endtask : rd_reg
endmodule : lxs_host

// ---- tb/lxs_regs_bench.sv ----
// Purpose: self-checking bench for the lin control and transceiver status registers
// Assumes: short time-outs of 16 and 32 cycles; inputs change at the falling edge
// Notes: the supply-ok input stays high; clock enable drops once to show the freeze
module lxs_regs_bench import lxs_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int DOM = 16; // shortened dominant time-out
  localparam int SIL = 32; // shortened silence time-out
  logic clk = 1'b0, rst = 1'b1, ce = 1'b1, vbat = 1'b1, rd, wr, rvalid, std;
  logic cts = 1'b0, fd = 1'b0, cfg = 1'b1, osc = 1'b0, act = 1'b1;
  logic [1:0] sbc = SBC_NORMAL, tx_n = 2'h3, tx_en, rx_en, dom, slope, trip;
  logic [3:0] mode;
  logic [6:0] addr;
  logic [7:0] wdata, rdata, d;
  lxs_lmode_t em;
  int n_mismatch = 0, comparisons = 0;

  lxs_host #(.NUM_LIN(2)) host (.clk(clk), .rdata(rdata), .rvalid(rvalid), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd));
  lxs_regs #(.NUM_LIN(2), .HAS_PN(1'b1), .DOM_CYC(DOM), .SIL_CYC(SIL)) dut (.CLK_SYS(clk), .RST(rst),
    .CE(ce), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata),
    .REG_RVALID(rvalid), .SBC_MODE(sbc), .LIN_VBAT_OK(vbat), .LIN_TX_INPUT_N(tx_n),
    .CAN_TX_READY(cts), .FD_FRAME_ERROR_FLAG(fd), .SELECTIVE_WAKE_CFG_VALID(cfg),
    .SELECTIVE_WAKE_OSC_LOCKED(osc), .CAN_BUS_ACTIVE(act), .LIN_MODE(mode), .LIN_TX_EN(tx_en),
    .LIN_RX_EN(rx_en), .LIN_DOM_DRIVE(dom), .LIN_SLOPE_ON(slope), .LIN_DTO_TRIP(trip),
    .STD_WAKE_ONLY(std));

  // 200 MHz clock
  initial begin
    forever #2.5 clk = ~clk;
  end

  // compare and count, mismatches reported at once
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk

  // single place where the run ends
  task automatic results();
    $display("mismatches %0d, comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : results

  // watchdog, far beyond the few hundred cycles the tests need
  initial begin
    #50us;
    n_mismatch++;
    results();
  end

  // main sequence
  initial begin
    repeat (8) @(negedge clk);
    rst = 1'b0;
    host.rd_reg(ADDR_LIN_CTRL, d);
    chk(d, LIN_CTRL_RST);
    host.rd_reg(7'h23, d);
    chk(d, 8'h00); // unmapped address reads zero
    // every op code in normal and standby; both channels share the code
    for (int s = 0; s < 2; s++) begin
      for (int op = 0; op < 4; op++) begin
        sbc = (s == 0) ? SBC_NORMAL : SBC_STANDBY;
        host.wr_reg(ADDR_LIN_CTRL, {2'h1, op[1:0], 2'h1, op[1:0]});
        repeat (2) @(negedge clk);
        em = (op == 3) ? LM_LISTEN : (s == 0 && op != 0) ? LM_ACTIVE : LM_OFFLINE;
        chk({4'h0, mode}, {4'h0, em, em});
        chk({6'h0, tx_en}, {6'h0, {2{em == LM_ACTIVE}}});
        chk({6'h0, rx_en}, {6'h0, {2{em != LM_OFFLINE}}});
        host.rd_reg(ADDR_LIN_CTRL, d);
        chk(d, {2'h1, op[1:0], 2'h1, op[1:0]});
      end
    end
    // stuck-low transmit pin with the time-out enabled, then disabled
    sbc = SBC_NORMAL;
    host.wr_reg(ADDR_LIN_CTRL, 8'h11);
    tx_n = 2'h0;
    repeat (4) @(negedge clk);
    chk({6'h0, dom}, 8'h03);
    chk({6'h0, trip}, 8'h00);
    chk({6'h0, slope}, 8'h03);
    repeat (DOM + 2) @(negedge clk);
    chk({6'h0, trip}, 8'h03);
    chk({6'h0, tx_en}, 8'h00);
    tx_n = 2'h3;
    repeat (4) @(negedge clk);
    chk({6'h0, trip}, 8'h00);
    chk({6'h0, tx_en}, 8'h03);
    host.wr_reg(ADDR_LIN_CTRL, 8'h99);
    tx_n = 2'h0;
    repeat (DOM + 8) @(negedge clk);
    chk({6'h0, trip}, 8'h00);
    chk({6'h0, slope}, 8'h03);
    chk({6'h0, tx_en}, 8'h03);
    tx_n = 2'h3;
    // clock enable low: a write is ignored and the old value stays
    ce = 1'b0;
    host.wr_reg(ADDR_LIN_CTRL, 8'h00);
    ce = 1'b1;
    host.rd_reg(ADDR_LIN_CTRL, d);
    chk(d, 8'h99);
    // status bits over every combination, bus kept active
    for (int i = 0; i < 16; i++) begin
      {cts, fd, cfg, osc} = i[3:0];
      repeat (4) @(negedge clk);
      host.rd_reg(ADDR_XCVR_STAT, d);
      chk(d, {cts, fd | ~cfg, cfg, osc, 4'h0});
      chk({7'h0, std}, {7'h0, fd | ~cfg});
    end
    // bus silence: not yet set short of the time-out, set after it
    act = 1'b0;
    repeat (SIL - 8) @(negedge clk);
    host.rd_reg(ADDR_XCVR_STAT, d);
    chk({7'h0, d[ST_QUIET]}, 8'h00);
    repeat (16) @(negedge clk);
    host.rd_reg(ADDR_XCVR_STAT, d);
    chk({7'h0, d[ST_QUIET]}, 8'h01);
    // status is read-only, a write there changes nothing
    host.wr_reg(ADDR_XCVR_STAT, 8'h00);
    host.rd_reg(ADDR_XCVR_STAT, d);
    chk(d, {cts, fd | ~cfg, cfg, osc, 4'h8});
    results();
  end
endmodule : lxs_regs_bench
